// ### design/twdp_port.sv
// Two-wire debug port: debug mode entry, bit engine on the debug clock pin,
// command framing, debug lock handling and hand-off of commands to the debug module.
// Assumes the pins come straight from pads outside the clock domain and that
// the debug module, lock setting and response data run on clk_i.
`timescale 1ns/1ps
module twdp_port (
  // Clock, reset and clock enable.
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              en_i,
  // Device pins.
  input  wire logic              reset_pin_n_i,
  input  wire logic              debug_clock_pin_i,
  input  wire logic              debug_data_pin_i,
  output logic                   debug_data_pin_o,
  output logic                   debug_data_pin_oe_o,
  // Device side state.
  input  wire logic              lock_setting_i,
  input  wire logic              lock_set_i,
  input  wire logic              erase_busy_i,
  input  wire logic [15:0]       rsp_data_i,
  output logic                   debug_mode_o,
  output logic                   lock_report_o,
  output logic                   erase_req_o,
  // Command stream to the debug module.
  output logic                   cmd_valid_o,
  output twdp_pkg::twdp_cmd_t    cmd_o,
  input  wire logic              cmd_ready_i
);

  typedef struct packed {
    logic                  clk_s1;
    logic                  clk_s2;
    logic                  clk_s3;
    logic                  dat_s1;
    logic                  dat_s2;
    logic                  rst_s1;
    logic                  rst_s2;
    logic                  rst_q;
    logic [1:0]            entry_cnt;
    logic                  dbg_mode;
    twdp_pkg::twdp_state_t st;
    logic [2:0]            bitcnt;
    logic [7:0]            sh;
    twdp_pkg::twdp_cmd_t   cmd;
    logic [1:0]            pidx;
    logic [1:0]            rcnt;
    logic [15:0]           rbuf;
    logic                  dout;
    logic                  doe;
    logic                  lock_flag;
    logic                  lock_rep;
    logic                  erase_ok;
    logic                  erase_req;
    logic                  pend;
    twdp_pkg::twdp_cmd_t   pend_cmd;
  } twdp_st_t;

  twdp_st_t            s_r;
  twdp_st_t            s_nxt;
  logic                fifo_in_ready;
  logic                clk_rise;
  logic                clk_fall;
  logic [7:0]          rx_byte;
  logic                done;
  twdp_pkg::twdp_cmd_t c;
  logic                is_erase;
  logic                is_status;
  logic                is_ident;
  logic                is_lockupd;
  logic                allowed;
  logic [1:0]          nret;
  logic [7:0]          status_byte;

  // Edges are found between the second and third stages only.
  assign clk_rise = s_r.clk_s2 && !s_r.clk_s3;
  assign clk_fall = !s_r.clk_s2 && s_r.clk_s3;
  assign rx_byte  = {s_r.sh[6:0], s_r.dat_s2};

  // Outputs come straight from state flip-flops.
  assign debug_data_pin_o    = s_r.dout;
  assign debug_data_pin_oe_o = s_r.doe;
  assign debug_mode_o        = s_r.dbg_mode;
  assign lock_report_o       = s_r.lock_rep;
  assign erase_req_o         = s_r.erase_req;

  // Status byte as seen by the host.
  always_comb begin
    status_byte                           = 8'h00;
    status_byte[twdp_pkg::STAT_LOCK_BIT]  = s_r.lock_rep;
    status_byte[twdp_pkg::STAT_ERASE_BIT] = erase_busy_i;
  end

  // Whole next-state function of the port.
  always_comb begin
    s_nxt     = s_r;
    done      = 1'b0;
    c         = s_r.cmd;
    is_erase  = 1'b0;
    is_status = 1'b0;
    is_ident  = 1'b0;
    is_lockupd = 1'b0;
    allowed   = 1'b0;
    nret      = 2'h0;

    // Pin synchronisers; the first stage feeds only the second.
    s_nxt.clk_s1 = debug_clock_pin_i;
    s_nxt.clk_s2 = s_r.clk_s1;
    s_nxt.clk_s3 = s_r.clk_s2;
    s_nxt.dat_s1 = debug_data_pin_i;
    s_nxt.dat_s2 = s_r.dat_s1;
    s_nxt.rst_s1 = reset_pin_n_i;
    s_nxt.rst_s2 = s_r.rst_s1;
    s_nxt.rst_q  = s_r.rst_s2;
    s_nxt.erase_req = 1'b0;

    // Software setting the lock takes effect on gating at once, not on the report.
    if (lock_set_i) begin
      s_nxt.lock_flag = 1'b1;
    end

    // The FIFO takes the pending command when it has room.
    if (s_r.pend && fifo_in_ready) begin
      s_nxt.pend = 1'b0;
    end

    if (!s_r.rst_s2) begin
      // Device reset: reload lock, rearm erase and count clock rises for entry.
      s_nxt.lock_flag = lock_setting_i;
      s_nxt.lock_rep  = lock_setting_i;
      s_nxt.erase_ok  = 1'b1;
      s_nxt.st        = twdp_pkg::TWDP_ST_CMD;
      s_nxt.bitcnt    = twdp_pkg::BIT_CNT_RST;
      s_nxt.doe       = 1'b0;
      if (s_r.rst_q) begin
        s_nxt.entry_cnt = 2'h0;
      end else if (clk_rise && s_r.entry_cnt != twdp_pkg::ENTRY_EDGES) begin
        s_nxt.entry_cnt = s_r.entry_cnt + 2'h1;
      end
    end else if (!s_r.rst_q) begin
      // Reset released: debug mode holds only if two rises were seen.
      s_nxt.dbg_mode = (s_r.entry_cnt == twdp_pkg::ENTRY_EDGES);
    end else if (!s_r.dbg_mode) begin
      // Outside debug mode the pins belong to general-purpose I/O.
      s_nxt.doe = 1'b0;
    end else begin
      unique case (s_r.st)
        twdp_pkg::TWDP_ST_CMD, twdp_pkg::TWDP_ST_PARAM: begin
          if (clk_fall) begin
            s_nxt.sh     = rx_byte;
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
            if (s_r.bitcnt == 3'h7) begin
              if (s_r.st == twdp_pkg::TWDP_ST_CMD) begin
                c.instr  = rx_byte[twdp_pkg::CMD_INSTR_MSB:twdp_pkg::CMD_INSTR_LSB];
                c.ret    = rx_byte[twdp_pkg::CMD_RET_BIT];
                c.nparam = rx_byte[twdp_pkg::CMD_CNT_MSB:twdp_pkg::CMD_CNT_LSB];
                c.param0 = 8'h00;
                c.param1 = 8'h00;
                c.param2 = 8'h00;
                s_nxt.pidx = 2'h0;
                if (c.nparam == 2'h0) begin
                  done = 1'b1;
                end else begin
                  s_nxt.st = twdp_pkg::TWDP_ST_PARAM;
                end
              end else begin
                unique case (s_r.pidx)
                  2'h0:    c.param0 = rx_byte;
                  2'h1:    c.param1 = rx_byte;
                  default: c.param2 = rx_byte;
                endcase
                s_nxt.pidx = s_r.pidx + 2'h1;
                done = (s_r.pidx + 2'h1 == s_r.cmd.nparam);
              end
              s_nxt.cmd = c;
            end
          end
        end
        twdp_pkg::TWDP_ST_RESP: begin
          if (clk_rise) begin
            // The host has let go of the line by now, so the device drives.
            s_nxt.doe    = 1'b1;
            s_nxt.dout   = s_r.rbuf[15];
            s_nxt.rbuf   = {s_r.rbuf[14:0], 1'b0};
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
          end else if (clk_fall && s_r.doe && s_r.bitcnt == 3'h0) begin
            // The host sampled the last bit of a byte on this edge.
            s_nxt.rcnt = s_r.rcnt - 2'h1;
            if (s_r.rcnt == 2'h1) begin
              s_nxt.doe = 1'b0;
              s_nxt.st  = twdp_pkg::TWDP_ST_CMD;
            end
          end
        end
        default: begin
          s_nxt.st  = twdp_pkg::TWDP_ST_CMD;
          s_nxt.doe = 1'b0;
        end
      endcase
    end

    // Command complete: check lock, act on local commands, queue the rest.
    if (done) begin
      is_erase   = (c.instr == twdp_pkg::INS_MASS_ERASE);
      is_status  = (c.instr == twdp_pkg::INS_STATUS_READ);
      is_ident   = (c.instr == twdp_pkg::INS_PART_IDENT);
      is_lockupd = (c.instr == twdp_pkg::INS_HALT) || (c.instr == twdp_pkg::INS_RESUME) ||
                   (c.instr == twdp_pkg::INS_INJECTED) ||
                   (c.instr == twdp_pkg::INS_SINGLE_STEP);
      allowed    = !s_r.lock_flag || is_erase || is_status || is_ident;
      if (is_erase && !s_r.erase_ok) begin
        allowed = 1'b0;
      end
      if (!is_status) begin
        s_nxt.erase_ok = 1'b0;
      end
      if (is_ident || c.instr == twdp_pkg::INS_GET_PC) begin
        nret = twdp_pkg::TWO_BYTES;
      end else begin
        nret = {1'b0, c.ret};
      end
      if (is_ident) begin
        s_nxt.rbuf = {twdp_pkg::PART_ID_VAL, twdp_pkg::PART_VER_VAL};
      end else if (is_status) begin
        s_nxt.rbuf = {status_byte, 8'h00};
      end else if (allowed) begin
        s_nxt.rbuf = rsp_data_i;
      end else begin
        s_nxt.rbuf = 16'h0000;
      end
      // A lock set in the same cycle as an erase survives it, so the tie never opens the port.
      if (allowed && is_erase) begin
        s_nxt.lock_flag = lock_set_i;
        s_nxt.lock_rep  = 1'b0;
        s_nxt.erase_req = 1'b1;
      end
      // The refresh happens even when the command itself is refused, else a newly set lock
      // would gate these commands and could never show up in the status byte.
      if (is_lockupd) begin
        s_nxt.lock_rep = s_nxt.lock_flag;
      end
      if (allowed && !is_status && !is_ident) begin
        s_nxt.pend     = 1'b1;
        s_nxt.pend_cmd = c;
      end
      s_nxt.bitcnt = twdp_pkg::BIT_CNT_RST;
      s_nxt.rcnt   = nret;
      s_nxt.st     = (nret != 2'h0) ? twdp_pkg::TWDP_ST_RESP : twdp_pkg::TWDP_ST_CMD;
    end
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r           <= '0;
      s_r.clk_s1    <= 1'b1;
      s_r.clk_s2    <= 1'b1;
      s_r.clk_s3    <= 1'b1;
      s_r.rst_s1    <= 1'b1;
      s_r.rst_s2    <= 1'b1;
      s_r.rst_q     <= 1'b1;
      s_r.erase_ok  <= 1'b1;
    end else if (en_i) begin
      s_r <= s_nxt;
    end
  end

  // Accepted commands queue here so a slow debug module stalls only the queue.
  twdp_fifo #(
    .WIDTH ($bits(twdp_pkg::twdp_cmd_t)),
    .DEPTH (twdp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .en_i        (en_i),
    .in_valid_i  (s_r.pend),
    .in_data_i   (s_r.pend_cmd),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (cmd_valid_o),
    .out_data_o  (cmd_o),
    .out_ready_i (cmd_ready_i)
  );

endmodule

// ### design/twdp_pkg.sv
// Package of the two-wire debug port: command codes, field positions,
// reset values and the command record passed to the on-chip debug module.
// Assumes nothing of its surroundings; the port and the bench files refer to it by scope.
package twdp_pkg;

  // Command byte fields.
  localparam int unsigned CMD_INSTR_MSB = 7;
  localparam int unsigned CMD_INSTR_LSB = 3;
  localparam int unsigned CMD_RET_BIT   = 2;
  localparam int unsigned CMD_CNT_MSB   = 1;
  localparam int unsigned CMD_CNT_LSB   = 0;

  // Instruction codes, the upper five bits of the command byte.
  localparam logic [4:0] INS_MASS_ERASE   = 5'h02;
  localparam logic [4:0] INS_GET_PC       = 5'h05;
  localparam logic [4:0] INS_STATUS_READ  = 5'h06;
  localparam logic [4:0] INS_HALT         = 5'h08;
  localparam logic [4:0] INS_RESUME       = 5'h09;
  localparam logic [4:0] INS_INJECTED     = 5'h0A;
  localparam logic [4:0] INS_SINGLE_STEP  = 5'h0B;
  localparam logic [4:0] INS_PART_IDENT   = 5'h0D;

  // Debug status byte layout.
  localparam int unsigned STAT_LOCK_BIT  = 2;
  localparam int unsigned STAT_ERASE_BIT = 7;

  // Identity returned by the part identification read; the values are arbitrary.
  localparam logic [7:0] PART_ID_VAL  = 8'h5A;
  localparam logic [7:0] PART_VER_VAL = 8'h01;

  // Counts and reset values.
  localparam logic [1:0] ENTRY_EDGES   = 2'h2;
  localparam logic [2:0] BIT_CNT_RST   = 3'h0;
  localparam logic [1:0] TWO_BYTES     = 2'h2;
  localparam int unsigned FIFO_DEPTH   = 4;

  // Link engine states.
  typedef enum logic [1:0] {
    TWDP_ST_CMD   = 2'b00,
    TWDP_ST_PARAM = 2'b01,
    TWDP_ST_RESP  = 2'b10
  } twdp_state_t;

  // One accepted command as handed to the debug module.
  typedef struct packed {
    logic [4:0] instr;
    logic       ret;
    logic [1:0] nparam;
    logic [7:0] param0;
    logic [7:0] param1;
    logic [7:0] param2;
  } twdp_cmd_t;

endpackage

// ### design/twdp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a registered output.
// Assumes one clock, an asynchronous active-low reset and a clock enable.
`timescale 1ns/1ps
module twdp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             en_i,
  // Filling side.
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side.
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        ovalid;
    logic [WIDTH-1:0]            odata;
  } twdp_fifo_st_t;

  twdp_fifo_st_t s_r;
  twdp_fifo_st_t s_nxt;
  logic          push;
  logic          pop;

  // The ready term is registered state, so the source sees a stall at once.
  assign in_ready_o  = (s_r.cnt != DEPTH[AW:0]);
  assign out_valid_o = s_r.ovalid;
  assign out_data_o  = s_r.odata;

  // Storage ring plus one output stage that refills whenever it empties.
  always_comb begin
    s_nxt = s_r;
    push  = in_valid_i && (s_r.cnt != DEPTH[AW:0]);
    pop   = (s_r.cnt != '0) && (!s_r.ovalid || out_ready_i);
    if (s_r.ovalid && out_ready_i) begin
      s_nxt.ovalid = 1'b0;
    end
    if (pop) begin
      s_nxt.ovalid = 1'b1;
      s_nxt.odata  = s_r.mem[s_r.rp];
      s_nxt.rp     = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + AW'(1);
    end
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp          = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + AW'(1);
    end
    s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else if (en_i) begin
      s_r <= s_nxt;
    end
  end

endmodule

// ### tb/twdp_port_props.sv
// Checker for the two-wire debug port: pin timing, entry, lock and command stream.
// Assumes debug clock half periods of at least four system clocks.
`timescale 1ns/1ps
module twdp_port_props (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // Watched ports.
  input  wire logic                reset_pin_n_i,
  input  wire logic                debug_clock_pin_i,
  input  wire logic                lock_setting_i,
  input  wire logic                debug_data_pin_o,
  input  wire logic                debug_data_pin_oe_o,
  input  wire logic                debug_mode_o,
  input  wire logic                lock_report_o,
  input  wire logic                erase_req_o,
  input  wire logic                cmd_valid_o,
  input  wire twdp_pkg::twdp_cmd_t cmd_o,
  input  wire logic                cmd_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [3:0] hi_cnt_r;

  // Cycles since the reset pin went high; saturates so it never wraps into range.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_cnt_r <= 4'h0;
    end else if (!reset_pin_n_i) begin
      hi_cnt_r <= 4'h0;
    end else if (hi_cnt_r != 4'hF) begin
      hi_cnt_r <= hi_cnt_r + 4'h1;
    end
  end

  sequence s_reset_held;
    !reset_pin_n_i [*6];
  endsequence
  sequence s_stalled;
    cmd_valid_o && !cmd_ready_i;
  endsequence

  chk_oe_needs_mode: assert property (debug_data_pin_oe_o |-> debug_mode_o)
    else $error("data pin driven outside debug mode");
  chk_mode_at_release: assert property ($changed(debug_mode_o) |-> hi_cnt_r inside {[1:10]})
    else $error("debug mode changed away from reset release");
  chk_data_on_rise: assert property (($changed(debug_data_pin_o) && debug_data_pin_oe_o
      && $past(debug_data_pin_oe_o)) |-> debug_clock_pin_i)
    else $error("returned bit changed while debug clock low");
  chk_drive_start: assert property ($rose(debug_data_pin_oe_o) |-> debug_clock_pin_i)
    else $error("device began driving off a rising edge");
  chk_drive_stop: assert property (($fell(debug_data_pin_oe_o) && reset_pin_n_i)
      |-> !debug_clock_pin_i)
    else $error("device released data line off a falling edge");
  chk_lock_reload: assert property (s_reset_held |-> lock_report_o == lock_setting_i)
    else $error("reported lock not loaded during device reset");
  chk_erase_clears: assert property (erase_req_o |-> ##[0:3] !lock_report_o)
    else $error("erase left the reported lock set");
  chk_erase_pulse: assert property (erase_req_o |=> !erase_req_o)
    else $error("erase request longer than one cycle");
  chk_cmd_hold: assert property (s_stalled |=> cmd_valid_o && $stable(cmd_o))
    else $error("command changed before it was taken");
endmodule

bind twdp_port twdp_port_props i_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .reset_pin_n_i(reset_pin_n_i),
  .debug_clock_pin_i(debug_clock_pin_i), .lock_setting_i(lock_setting_i),
  .debug_data_pin_o(debug_data_pin_o), .debug_data_pin_oe_o(debug_data_pin_oe_o),
  .debug_mode_o(debug_mode_o), .lock_report_o(lock_report_o), .erase_req_o(erase_req_o),
  .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_ready_i(cmd_ready_i));

// ### tb/twdp_host_model.sv
// Behavioural debug host driving the reset pin, the debug clock and the data line.
// Assumes the bench resolves the data line from both drivers.
`timescale 1ns/1ps
module twdp_host_model (
  // Resolved data line.
  input  wire logic data_line_i,
  // Pins driven by the host.
  output logic      reset_pin_n_o,
  output logic      debug_clock_o,
  output logic      data_o,
  output logic      data_oe_o
);
  localparam realtime HALF = 62.5;

  // The clock idles low so the device sees no stray edges between frames.
  initial begin
    reset_pin_n_o = 1'b1;
    debug_clock_o = 1'b0;
    data_o = 1'b0;
    data_oe_o = 1'b0;
  end

  // Holds reset low and gives the chosen number of clock rises.
  task automatic enter(input int rises);
    reset_pin_n_o = 1'b0;
    #HALF;
    repeat (rises) begin
      debug_clock_o = 1'b1;
      #HALF;
      debug_clock_o = 1'b0;
      #HALF;
    end
    reset_pin_n_o = 1'b1;
    #(4 * HALF);
  endtask

  // Data changes with the rising edge; the device samples on the falling one.
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      debug_clock_o = 1'b1;
      data_o = b[i];
      data_oe_o = 1'b1;
      #HALF;
      debug_clock_o = 1'b0;
      #HALF;
    end
  endtask

  // The line is let go at the first rise so the device can take it over.
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      debug_clock_o = 1'b1;
      data_oe_o = 1'b0;
      #HALF;
      b[i] = data_line_i;
      debug_clock_o = 1'b0;
      #HALF;
    end
  endtask

  // Ends a command with the line released.
  task automatic release_line();
    data_oe_o = 1'b0;
    #HALF;
  endtask
endmodule

// ### tb/test_two_wire_debug_port.sv
// Self-checking bench of the debug port with a behavioural host on the pins.
// Assumes the checker is bound to the port and the host model sits beside it.
`timescale 1ns/1ps
module test_two_wire_debug_port;
  logic                clk_i = 1'b0;
  logic                arst_n_i = 1'b0;
  logic                lock_setting_i = 1'b0;
  logic                lock_set_i = 1'b0;
  logic                erase_busy_i = 1'b0;
  logic                cmd_ready_i = 1'b0;
  logic                stall = 1'b0;
  logic                last_drv = 1'b0;
  logic [15:0]         rsp_data_i = 16'h0000;
  logic                dut_d, dut_oe, host_d, host_oe, rst_pin_n, dbg_clk, data_line;
  logic                mode, lock_rep, erase_req, cmd_valid;
  twdp_pkg::twdp_cmd_t cmd;
  twdp_pkg::twdp_cmd_t got_q[$];
  int                  n_mismatch = 0;
  int                  compares = 0;
  int                  erase_cnt = 0;

  twdp_port i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .en_i(1'b1), .reset_pin_n_i(rst_pin_n),
    .debug_clock_pin_i(dbg_clk), .debug_data_pin_i(data_line), .debug_data_pin_o(dut_d),
    .debug_data_pin_oe_o(dut_oe), .lock_setting_i(lock_setting_i), .lock_set_i(lock_set_i),
    .erase_busy_i(erase_busy_i), .rsp_data_i(rsp_data_i), .debug_mode_o(mode),
    .lock_report_o(lock_rep), .erase_req_o(erase_req), .cmd_valid_o(cmd_valid),
    .cmd_o(cmd), .cmd_ready_i(cmd_ready_i));
  twdp_host_model i_host (.data_line_i(data_line), .reset_pin_n_o(rst_pin_n),
    .debug_clock_o(dbg_clk), .data_o(host_d), .data_oe_o(host_oe));

  // A released line shows the inverse of its last level so a stale bit never passes.
  assign data_line = dut_oe ? dut_d : (host_oe ? host_d : ~last_drv);

  initial forever #4 clk_i = ~clk_i;

  // Collects taken commands and erase pulses, then draws the next ready value.
  always @(posedge clk_i) begin
    if (dut_oe || host_oe) last_drv <= data_line;
    if (erase_req === 1'b1) erase_cnt++;
    if (cmd_valid === 1'b1 && cmd_ready_i === 1'b1) got_q.push_back(cmd);
    #1 cmd_ready_i = !stall && ($urandom_range(3, 0) != 0);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  function automatic logic [7:0] stat(input logic lk, input logic busy);
    return {busy, 4'h0, lk, 2'h0};
  endfunction

  // Parameter bytes beyond the count carry no meaning and are masked off.
  function automatic logic [31:0] keep(input logic [31:0] v, input logic [1:0] n);
    return v & {8'hFF, 24'hFF_FFFF << (8 * (3 - n))};
  endfunction

  task automatic run_cmd(input logic [7:0] c, input logic [23:0] prm, input int nret,
                         output logic [15:0] rx);
    logic [7:0] b;
    rx = 16'h0000;
    i_host.put_byte(c);
    for (int i = 0; i < int'(c[1:0]); i++) i_host.put_byte(prm[23 - 8 * i -: 8]);
    for (int i = 0; i < nret; i++) begin
      i_host.get_byte(b);
      rx = {rx[7:0], b};
    end
    i_host.release_line();
  endtask

  task automatic expect_cmd(input logic [7:0] c, input logic [23:0] prm);
    int t;
    t = 0;
    while (got_q.size() == 0 && t < 80) begin
      tick(1);
      t++;
    end
    check(32'(got_q.size() != 0), 32'h1);
    if (got_q.size() != 0) check(keep(got_q.pop_front(), c[1:0]), keep({c, prm}, c[1:0]));
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // About twenty-six short commands take well under this span.
  initial begin
    #400us;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [15:0] rx;
    logic [7:0]  c;
    logic [23:0] p;
    int          e0;
    void'($urandom(32'h8DFA));
    tick(8);
    arst_n_i = 1'b1;
    tick(4);
    i_host.enter(1);
    check(mode, 1'b0);
    i_host.enter(2);
    check(mode, 1'b1);
    $display("test entry done");
    tick(1);
    erase_busy_i = 1'($urandom_range(1, 0));
    run_cmd(8'h34, 24'h0, 1, rx);
    check(rx[7:0], stat(1'b0, erase_busy_i));
    run_cmd(8'h68, 24'h0, 2, rx);
    check(rx, {twdp_pkg::PART_ID_VAL, twdp_pkg::PART_VER_VAL});
    tick(30);
    check(got_q.size(), 0);
    $display("test local reads done");
    for (int i = 0; i < 10; i++) begin
      c = {5'h08 + 5'($urandom_range(3, 0)), 1'b0, 2'($urandom_range(3, 0))};
      if (i == 0) c = 8'h28;
      if (i == 1) c[1:0] = 2'h3;
      if (i == 2) c[2] = 1'b1;
      p = 24'($urandom);
      tick(1);
      rsp_data_i = 16'($urandom);
      run_cmd(c, p, (i == 0) ? 2 : int'(c[2]), rx);
      if (i == 0) check(rx, rsp_data_i);
      if (i == 2) check(rx[7:0], rsp_data_i[15:8]);
      expect_cmd(c, p);
    end
    $display("test random stream done");
    stall = 1'b1;
    for (int i = 0; i < 5; i++) run_cmd(8'h51, {8'(i + 16), 16'h0}, 0, rx);
    tick(4);
    check(got_q.size(), 0);
    stall = 1'b0;
    for (int i = 0; i < 5; i++) expect_cmd(8'h51, {8'(i + 16), 16'h0});
    e0 = erase_cnt;
    run_cmd(8'h10, 24'h0, 0, rx);
    tick(20);
    check(erase_cnt - e0, 0);
    got_q.delete();
    $display("test buffer and late erase done");
    tick(1);
    lock_setting_i = 1'b1;
    i_host.enter(2);
    run_cmd(8'h34, 24'h0, 1, rx);
    check(rx[7:0], stat(1'b1, erase_busy_i));
    check(lock_rep, 1'b1);
    e0 = erase_cnt;
    run_cmd(8'h10, 24'h0, 0, rx);
    tick(20);
    check(erase_cnt - e0, 1);
    check(lock_rep, 1'b0);
    got_q.delete();
    lock_setting_i = 1'b0;
    run_cmd(8'h34, 24'h0, 1, rx);
    check(rx[7:0], stat(1'b0, erase_busy_i));
    run_cmd(8'h40, 24'h0, 0, rx);
    expect_cmd(8'h40, 24'h0);
    tick(1);
    lock_set_i = 1'b1;
    tick(1);
    lock_set_i = 1'b0;
    run_cmd(8'h34, 24'h0, 1, rx);
    check(rx[7:0], stat(1'b0, erase_busy_i));
    run_cmd(8'h40, 24'h0, 0, rx);
    run_cmd(8'h34, 24'h0, 1, rx);
    check(rx[7:0], stat(1'b1, erase_busy_i));
    run_cmd(8'h6C, 24'h0, 2, rx);
    check(rx, {twdp_pkg::PART_ID_VAL, twdp_pkg::PART_VER_VAL});
    tick(40);
    check(got_q.size(), 0);
    $display("test lock done");
    print_verdict();
  end
endmodule
